/* File: rtl/eswp_pkg.sv */
// constants shared by the protection-register device end and its two-wire host end
// assumes both ends sit on one system clock; the link clock is sampled, never used as a clock
//
// Functional notes
// R1 - type identifier in address bits 7..4
// R2 - hardware address bits 3..2, bit0 direction
// R3 - 8-Kbit ignores address bit 2 (register only in the code; array addresses still compare it)
// R4 - word address top bits 11 select register
// R5 - read returns zero upper nibble
// R6 - bit3 enables software protection
// R7 - bits 2:1 choose protected upper region
// R8 - disabled means whole array writable
// R9 - 4-Kbit protected ranges per block select
// R10 - 8-Kbit protected ranges per block select
// R11 - lock bit makes register permanent
// R12 - host writes one data byte then stop
// R13 - write upper nibble 4h or 6h
// R14 - confirm bit must equal lock bit
// R15 - extra data bytes abort register write
// R16 - locked register skips write cycle
// R17 - register read only by random read
// R18 - protected array writes acked, then aborted
// R19 - no address ack during write cycle
// R20 - register contents survive power loss
// R21 - protection checked at stop condition
package eswp_pkg;
    // ==========================================
    // address bytes
    localparam logic [3:0] REG_TYPE_ID   = 4'hA;   // arbitrary value, stands in for the real identifier
    localparam logic [3:0] ARRAY_TYPE_ID = 4'h5;   // arbitrary value
    localparam int         DEV_TYPE_MSB  = 7;
    localparam int         DEV_TYPE_LSB  = 4;
    localparam int         DEV_HW_HI     = 3;
    localparam int         DEV_HW_LO     = 2;
    localparam int         DEV_RW_BIT    = 0;
    localparam logic [1:0] WADDR_REG_SEL = 2'h3;
    // ==========================================
    // register fields
    localparam int         REG_EN_BIT    = 3;
    localparam int         REG_BS_HI     = 2;
    localparam int         REG_BS_LO     = 1;
    localparam int         REG_LOCK_BIT  = 0;
    localparam int         WR_CONFIRM    = 5;
    localparam int         WR_MARK       = 6;
    localparam int         WR_ZERO_HI    = 7;
    localparam int         WR_ZERO_LO    = 4;
    localparam logic [3:0] REG_RESET     = 4'h0;
    // ==========================================
    // timing
    localparam int         CLK_NS        = 100;
    localparam int         TWR_US        = 5000;
    localparam int         TWR_CYC       = (TWR_US * 1000) / CLK_NS;
    localparam int         SCL_HALF      = 4;
    localparam int         CNT_W         = 16;
endpackage

/* File: rtl/eswp_if.sv */
// two-wire link between host end and device end
// assumes open-drain wiring resolved here from enables; pull-up when nobody drives low
`timescale 1ns/1ps
`default_nettype none
interface eswp_if;
    logic sclOut;
    logic sclOe;
    logic sdaHostOut;
    logic sdaHostOe;
    logic sdaDevOut;
    logic sdaDevOe;
    logic scl;
    logic sda;
    assign scl = ~(sclOe & ~sclOut);
    assign sda = ~((sdaHostOe & ~sdaHostOut) | (sdaDevOe & ~sdaDevOut));
    modport host (output sclOut, sclOe, sdaHostOut, sdaHostOe, input scl, sda);
    modport dev (output sdaDevOut, sdaDevOe, input scl, sda);
endinterface
`default_nettype wire

/* File: rtl/eswp_device.sv */
// device end: two-wire slave holding the protection register and gating array writes
// assumes link pins sampled on clock; array storage itself lives outside this block
`timescale 1ns/1ps
`default_nettype none
module eswp_device #(
    parameter int TWR_CYCLES = eswp_pkg::TWR_CYC
) (
    // system
    input  wire logic       clock,
    input  wire logic       srst,
    input  wire logic       clkEn,
    // link
    eswp_if.dev             link,
    // strap and variant
    input  wire logic [1:0] hwAddr,
    input  wire logic       is8k,
    // nonvolatile image
    input  wire logic       nvValid,
    input  wire logic [3:0] nvImage,
    // user side
    output logic [3:0]      protReg,
    output logic            arrayWrStb,
    output logic [9:0]      arrayWrAddr,
    output logic [7:0]      arrayWrData,
    output logic            busy
);
    typedef enum {S_IDLE, S_DEV, S_WADDR, S_DATA, S_READ, S_ACK, S_RACK} eswp_dst_t;
    eswp_dst_t   state_ff;
    logic [2:0]  sclSync_ff, sdaSync_ff;
    logic [3:0]  reg_ff;
    logic        regLoaded_ff;
    logic [7:0]  shift_ff, devByte_ff, wAddr_ff, data_ff;
    logic [3:0]  bitCnt_ff;
    logic [1:0]  nData_ff;
    logic        isReg_ff, ackBit_ff, after_ff, pendWr_ff;
    logic        gotDev_ff, wDone_ff, busy_ff;
    logic [eswp_pkg::CNT_W+6:0] twr_ff;
    logic        sdaOut_ff;
    logic        strobe_ff;
    logic [9:0]  addr_ff;
    logic [7:0]  wdata_ff;
    logic        sclRise, sclFall, startC, stopC;
    logic        idMatch, regId, arrId, protHit;
    logic [9:0]  tgt;
    logic [9:0]  lowBound;

    // ==========================================
    // pin sampling, edges only on stage two and three
    always_ff @(posedge clock) begin
        if (srst) begin
            sclSync_ff <= 3'h7;
            sdaSync_ff <= 3'h7;
        end else if (clkEn) begin
            sclSync_ff <= {sclSync_ff[1:0], link.scl};
            sdaSync_ff <= {sdaSync_ff[1:0], link.sda};
        end
    end
    assign sclRise = sclSync_ff[1] & ~sclSync_ff[2];
    assign sclFall = ~sclSync_ff[1] & sclSync_ff[2];
    assign startC  = sclSync_ff[2] & sclSync_ff[1] & sdaSync_ff[2] & ~sdaSync_ff[1];
    assign stopC   = sclSync_ff[2] & sclSync_ff[1] & ~sdaSync_ff[2] & sdaSync_ff[1];

    // ==========================================
    // address decode
    assign regId   = shift_ff[eswp_pkg::DEV_TYPE_MSB:eswp_pkg::DEV_TYPE_LSB] == eswp_pkg::REG_TYPE_ID; // R1
    assign arrId   = shift_ff[eswp_pkg::DEV_TYPE_MSB:eswp_pkg::DEV_TYPE_LSB] == eswp_pkg::ARRAY_TYPE_ID;
    assign idMatch = (regId | arrId)
                   & (shift_ff[eswp_pkg::DEV_HW_HI] == hwAddr[1]) // R2
                   & ((regId & is8k) | (shift_ff[eswp_pkg::DEV_HW_LO] == hwAddr[0])); // R3

    // ==========================================
    // protection window
    assign tgt = is8k ? {devByte_ff[eswp_pkg::DEV_HW_LO], devByte_ff[1], wAddr_ff}
                      : {1'b0, devByte_ff[1], wAddr_ff};
    always_comb begin
        case (reg_ff[eswp_pkg::REG_BS_HI:eswp_pkg::REG_BS_LO]) // R7
            2'h0:    lowBound = is8k ? 10'h300 : 10'h180; // R9 R10
            2'h1:    lowBound = is8k ? 10'h200 : 10'h100;
            2'h2:    lowBound = is8k ? 10'h100 : 10'h080;
            default: lowBound = 10'h000;
        endcase
    end
    assign protHit = reg_ff[eswp_pkg::REG_EN_BIT] & (tgt >= lowBound); // R6 R8

    // ==========================================
    // protocol engine
    always_ff @(posedge clock) begin
        if (srst) begin
            state_ff   <= S_IDLE;
            shift_ff   <= 8'h00;
            devByte_ff <= 8'h00;
            wAddr_ff   <= 8'h00;
            data_ff    <= 8'h00;
            bitCnt_ff  <= 4'h0;
            nData_ff   <= 2'h0;
            isReg_ff   <= 1'b0;
            ackBit_ff  <= 1'b0;
            after_ff   <= 1'b0;
            sdaOut_ff  <= 1'b1;
            pendWr_ff  <= 1'b0;
            gotDev_ff  <= 1'b0;
            wDone_ff   <= 1'b0;
        end else if (clkEn) begin
            pendWr_ff <= 1'b0;
            if (startC) begin
                state_ff  <= S_DEV;
                bitCnt_ff <= 4'h0;
                sdaOut_ff <= 1'b1;
            end else if (stopC) begin
                state_ff  <= S_IDLE;
                sdaOut_ff <= 1'b1;
                pendWr_ff <= (state_ff == S_DATA || state_ff == S_ACK) & (nData_ff != 2'h0); // R21
                wDone_ff  <= 1'b0;
            end else begin
                case (state_ff)
                    S_DEV, S_WADDR, S_DATA: begin
                        if (sclRise) begin
                            shift_ff  <= {shift_ff[6:0], sdaSync_ff[2]};
                            bitCnt_ff <= bitCnt_ff + 4'h1;
                        end
                        if (sclFall && bitCnt_ff == 4'h8) begin
                            bitCnt_ff <= 4'h0;
                            ackBit_ff <= 1'b0;
                            after_ff  <= 1'b0;
                            gotDev_ff <= state_ff == S_DEV;
                            if (state_ff == S_DEV) begin
                                devByte_ff <= shift_ff;
                                // a read reaches the register only right after its dummy write
                                isReg_ff   <= regId & (~shift_ff[eswp_pkg::DEV_RW_BIT]
                                              | (wDone_ff & (wAddr_ff[7:6] == eswp_pkg::WADDR_REG_SEL))); // R17
                                wDone_ff   <= 1'b0;
                                ackBit_ff  <= idMatch & (twr_ff == '0); // R19
                                after_ff   <= shift_ff[eswp_pkg::DEV_RW_BIT];
                                nData_ff   <= 2'h0;
                                sdaOut_ff  <= ~(idMatch & (twr_ff == '0));
                            end else if (state_ff == S_WADDR) begin
                                wAddr_ff  <= shift_ff;
                                wDone_ff  <= 1'b1;
                                isReg_ff  <= isReg_ff & (shift_ff[7:6] == eswp_pkg::WADDR_REG_SEL); // R4
                                ackBit_ff <= 1'b1;
                                sdaOut_ff <= 1'b0;
                            end else begin
                                data_ff   <= shift_ff;
                                nData_ff  <= (nData_ff == 2'h3) ? 2'h3 : nData_ff + 2'h1; // R15
                                ackBit_ff <= 1'b1; // R18
                                sdaOut_ff <= 1'b0;
                            end
                            state_ff <= S_ACK;
                        end
                    end
                    S_ACK: begin
                        if (sclFall) begin
                            sdaOut_ff <= 1'b1;
                            if (!ackBit_ff) begin
                                state_ff <= S_IDLE;
                            end else if (devByte_ff[eswp_pkg::DEV_RW_BIT] && after_ff) begin
                                state_ff  <= S_READ; // R17
                                shift_ff  <= isReg_ff ? {4'h0, reg_ff} : 8'hFF; // R5
                                sdaOut_ff <= isReg_ff ? 1'b0 : 1'b1;
                            end else begin
                                // flag, not byte compare: a word address may equal the device byte
                                state_ff <= gotDev_ff ? S_WADDR : S_DATA;
                            end
                        end
                    end
                    S_READ: begin
                        if (sclFall) begin
                            bitCnt_ff <= bitCnt_ff + 4'h1;
                            shift_ff  <= {shift_ff[6:0], 1'b0};
                            sdaOut_ff <= (bitCnt_ff == 4'h7) ? 1'b1 : shift_ff[6];
                            if (bitCnt_ff == 4'h7) begin
                                state_ff <= S_RACK;
                            end
                        end
                    end
                    S_RACK: begin
                        if (sclRise) begin
                            state_ff <= S_IDLE; // nack or ack both end: register is one byte
                        end
                    end
                    default: state_ff <= S_IDLE;
                endcase
            end
        end
    end

    // ==========================================
    // register, nonvolatile image and write cycle
    always_ff @(posedge clock) begin
        if (srst) begin
            reg_ff       <= eswp_pkg::REG_RESET;
            regLoaded_ff <= 1'b0;
            twr_ff       <= '0;
            strobe_ff    <= 1'b0;
            addr_ff      <= 10'h000;
            wdata_ff     <= 8'h00;
            busy_ff      <= 1'b0;
        end else if (clkEn) begin
            strobe_ff <= 1'b0;
            if (!regLoaded_ff && nvValid) begin
                reg_ff       <= nvImage; // R20
                regLoaded_ff <= 1'b1;
            end
            if (twr_ff != '0) begin
                twr_ff  <= twr_ff - 1'b1;
                busy_ff <= twr_ff != (eswp_pkg::CNT_W+7)'(1);
            end
            if (pendWr_ff) begin
                if (isReg_ff) begin
                    if (!reg_ff[eswp_pkg::REG_LOCK_BIT] // R11 R16
                        && nData_ff == 2'h1 // R15
                        && data_ff[eswp_pkg::WR_CONFIRM] == data_ff[eswp_pkg::REG_LOCK_BIT] // R14
                        && data_ff[eswp_pkg::WR_MARK] && !data_ff[eswp_pkg::WR_ZERO_HI]
                        && !data_ff[eswp_pkg::WR_ZERO_LO]) begin
                        reg_ff  <= data_ff[3:0];
                        twr_ff  <= (eswp_pkg::CNT_W+7)'(TWR_CYCLES);
                        busy_ff <= 1'b1;
                    end
                end else if (!protHit) begin // R18
                    strobe_ff <= 1'b1;
                    addr_ff   <= tgt;
                    wdata_ff  <= data_ff;
                    twr_ff    <= (eswp_pkg::CNT_W+7)'(TWR_CYCLES);
                    busy_ff   <= 1'b1;
                end
            end
        end
    end

    assign link.sdaDevOut = 1'b0;
    assign link.sdaDevOe  = ~sdaOut_ff;
    assign protReg        = reg_ff;
    assign arrayWrStb     = strobe_ff;
    assign arrayWrAddr    = addr_ff;
    assign arrayWrData    = wdata_ff;
    assign busy           = busy_ff;
endmodule
`default_nettype wire

/* File: rtl/eswp_host.sv */
// host end: issues register writes and random reads of the protection register
// assumes device answers on the shared open-drain link; scl made here by a divider
`timescale 1ns/1ps
`default_nettype none
module eswp_host (
    // system
    input  wire logic       clock,
    input  wire logic       srst,
    input  wire logic       clkEn,
    // link
    eswp_if.host            link,
    // user side
    input  wire logic       cmdValid,
    input  wire logic       cmdRead,
    input  wire logic [1:0] cmdHwAddr,
    input  wire logic [3:0] cmdValue,
    input  wire logic       cmdLock,
    output logic            cmdReady,
    output logic            rspValid,
    output logic [7:0]      rspData,
    output logic            rspNack
);
    typedef enum {H_IDLE, H_START, H_BYTE, H_ACK, H_RSTART, H_RBYTE, H_RNACK, H_STOP} eswp_hst_t;
    eswp_hst_t  state_ff;
    logic [2:0] div_ff;
    logic [1:0] phase_ff;
    logic [1:0] sdaSync_ff;
    logic [7:0] bytes_ff [3];
    logic [1:0] idx_ff;
    logic [3:0] bit_ff;
    logic [7:0] rx_ff;
    logic       rd_ff, nack_ff, scl_ff, sda_ff, ready_ff, rv_ff;
    logic [7:0] rdat_ff;
    logic       tick;

    assign tick = div_ff == 3'(eswp_pkg::SCL_HALF - 1);
    always_ff @(posedge clock) begin
        if (srst) begin
            div_ff <= 3'h0;
        end else if (clkEn) begin
            div_ff <= tick ? 3'h0 : div_ff + 3'h1;
        end
    end
    always_ff @(posedge clock) begin
        if (srst) begin
            sdaSync_ff <= 2'h3;
        end else if (clkEn) begin
            sdaSync_ff <= {sdaSync_ff[0], link.sda};
        end
    end

    // ==========================================
    // sequencer, one quarter bit per tick
    always_ff @(posedge clock) begin
        if (srst) begin
            state_ff <= H_IDLE;
            phase_ff <= 2'h0;
            idx_ff   <= 2'h0;
            bit_ff   <= 4'h0;
            rx_ff    <= 8'h00;
            rd_ff    <= 1'b0;
            nack_ff  <= 1'b0;
            scl_ff   <= 1'b1;
            sda_ff   <= 1'b1;
            ready_ff <= 1'b1;
            rv_ff    <= 1'b0;
            rdat_ff  <= 8'h00;
            for (int i = 0; i < 3; i++) begin
                bytes_ff[i] <= 8'h00;
            end
        end else if (clkEn) begin
            rv_ff <= 1'b0;
            if (state_ff == H_IDLE) begin
                if (cmdValid && ready_ff) begin
                    ready_ff    <= 1'b0;
                    rd_ff       <= cmdRead;
                    nack_ff     <= 1'b0;
                    bytes_ff[0] <= {eswp_pkg::REG_TYPE_ID, cmdHwAddr, 2'b00}; // R1 R2
                    bytes_ff[1] <= {eswp_pkg::WADDR_REG_SEL, 6'h00}; // R4
                    bytes_ff[2] <= {1'b0, 1'b1, cmdLock, 1'b0, cmdValue[3:1], cmdLock}; // R13 R14
                    idx_ff      <= 2'h0;
                    state_ff    <= H_START;
                    phase_ff    <= 2'h0;
                end
            end else if (tick) begin
                phase_ff <= phase_ff + 2'h1;
                case (state_ff)
                    H_START, H_RSTART: begin
                        case (phase_ff)
                            2'h0: begin sda_ff <= 1'b1; scl_ff <= 1'b1; end
                            2'h1: sda_ff <= 1'b0;
                            2'h2: scl_ff <= 1'b0;
                            default: begin
                                bit_ff   <= 4'h0;
                                state_ff <= H_BYTE;
                            end
                        endcase
                    end
                    H_BYTE, H_ACK, H_RBYTE, H_RNACK: begin
                        case (phase_ff)
                            2'h0: begin
                                if (state_ff == H_BYTE) begin
                                    sda_ff <= bytes_ff[idx_ff][3'(7 - bit_ff)];
                                end else begin
                                    // released: device acks or sends data, and a high slot is our nack
                                    sda_ff <= 1'b1;
                                end
                            end
                            2'h1: scl_ff <= 1'b1;
                            2'h2: begin
                                if (state_ff == H_RBYTE) begin
                                    rx_ff <= {rx_ff[6:0], sdaSync_ff[1]};
                                end
                                if (state_ff == H_ACK && sdaSync_ff[1]) begin
                                    nack_ff <= 1'b1;
                                end
                            end
                            default: begin
                                scl_ff <= 1'b0;
                                bit_ff <= bit_ff + 4'h1;
                                if (state_ff == H_BYTE && bit_ff == 4'h7) begin
                                    state_ff <= H_ACK;
                                end else if (state_ff == H_RBYTE && bit_ff == 4'h7) begin
                                    state_ff <= H_RNACK;
                                end else if (state_ff == H_ACK) begin
                                    bit_ff <= 4'h0;
                                    if (nack_ff) begin
                                        state_ff <= H_STOP;
                                    end else if (rd_ff && idx_ff == 2'h1) begin
                                        state_ff    <= H_RSTART; // R17
                                        bytes_ff[0] <= bytes_ff[0] | 8'h01;
                                        idx_ff      <= 2'h0;
                                        rd_ff       <= 1'b0;
                                    end else if (bytes_ff[0][0]) begin
                                        state_ff <= H_RBYTE;
                                    end else if (idx_ff == 2'h2) begin
                                        state_ff <= H_STOP; // R12
                                    end else begin
                                        idx_ff   <= idx_ff + 2'h1;
                                        state_ff <= H_BYTE;
                                    end
                                end else if (state_ff == H_RNACK) begin
                                    state_ff <= H_STOP;
                                end
                            end
                        endcase
                    end
                    H_STOP: begin
                        case (phase_ff)
                            2'h0: sda_ff <= 1'b0;
                            2'h1: scl_ff <= 1'b1;
                            2'h2: sda_ff <= 1'b1;
                            default: begin
                                state_ff <= H_IDLE;
                                ready_ff <= 1'b1;
                                rv_ff    <= 1'b1;
                                rdat_ff  <= rx_ff;
                            end
                        endcase
                    end
                    default: state_ff <= H_IDLE;
                endcase
            end
        end
    end

    assign link.sclOut     = 1'b0;
    assign link.sclOe      = ~scl_ff;
    assign link.sdaHostOut = 1'b0;
    assign link.sdaHostOe  = ~sda_ff;
    assign cmdReady        = ready_ff;
    assign rspValid        = rv_ff;
    assign rspData         = rdat_ff;
    assign rspNack         = nack_ff;
endmodule
`default_nettype wire

/* File: sim/eswp_link_sva.sv */
// checker for the two-wire link and the device register behaviour
// assumes it sits in the bench beside the link interface, one clock domain
`timescale 1ns/1ps
`default_nettype none
module eswp_link_sva #(
    parameter int TWR_CYCLES = 20
) (
    // system
    input wire logic       clock,
    input wire logic       srst,
    // link and device
    input wire logic       scl,
    input wire logic       sdaDevOe,
    input wire logic [3:0] protReg,
    input wire logic [3:0] nvImage,
    input wire logic       busy,
    // host user side
    input wire logic       cmdReady,
    input wire logic       rspValid,
    input wire logic       rspNack
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    // ==========================================
    // busy length: too long for a repetition, so counted
    logic [31:0] busyCnt_ff;
    always_ff @(posedge clock) begin
        if (srst || !busy) begin
            busyCnt_ff <= 32'h0;
        end else begin
            busyCnt_ff <= busyCnt_ff + 32'h1;
        end
    end
    // ==========================================
    // properties
    property p_lock_sticky; $past(protReg[0]) && !$past(srst) |-> protReg[0]; endproperty
    property p_lock_frozen; $past(protReg[0]) && !$past(srst) |-> $stable(protReg); endproperty
    property p_nv_load; $fell(srst) |-> ##[0:3] protReg == nvImage; endproperty
    property p_busy_min; $rose(busy) |-> busy [*8]; endproperty
    property p_busy_max; busyCnt_ff <= TWR_CYCLES + 1; endproperty
    property p_no_ack_busy; busy |-> !sdaDevOe; endproperty
    property p_dev_scl_low; !$stable(sdaDevOe) |-> !scl; endproperty
    property p_idle_lines; cmdReady |-> scl && !sdaDevOe; endproperty
    a_lock_sticky:
        assert property (p_lock_sticky) else $error("lock bit cleared");
    a_lock_frozen:
        assert property (p_lock_frozen) else $error("locked register changed");
    a_nv_load:
        assert property (p_nv_load) else $error("stored image not restored");
    a_busy_min:
        assert property (p_busy_min) else $error("write cycle too short");
    a_busy_max:
        assert property (p_busy_max) else $error("write cycle too long");
    a_no_ack_busy:
        assert property (p_no_ack_busy) else $error("device drove line while busy");
    a_dev_scl_low:
        assert property (p_dev_scl_low) else $error("device data moved with clock high");
    a_idle_lines:
        assert property (p_idle_lines) else $error("link not idle between commands");
    c_busy: cover property ($rose(busy));
    c_lock: cover property ($rose(protReg[0]));
    c_nack: cover property (rspValid && rspNack);
endmodule
`default_nettype wire

/* File: sim/eswp_software_write_protect_tb_top.sv */
// bench joining host end and device end over the link, random register traffic
// assumes the write cycle is shortened so back-to-back commands meet it
`timescale 1ns/1ps
`default_nettype none
module eswp_software_write_protect_tb_top;
    localparam int TWR = 400;
    logic clock = 1'b0, srst = 1'b1, is8k = 1'b0, cmdValid = 1'b0, cmdRead = 1'b0, cmdLock = 1'b0;
    logic [1:0] hwAddr = 2'h2, cmdHwAddr = 2'h0;
    logic [3:0] cmdValue = 4'h0, protReg, expReg;
    logic cmdReady, rspValid, rspNack, busy, arrayWrStb;
    logic [7:0] rspData;
    logic [31:0] seed = 32'h1CEA;
    logic [1:0] hw;
    logic ok, acc, bz, lk;
    int n_mismatch = 0, n_checks = 0;
    eswp_if link();
    eswp_device #(.TWR_CYCLES(TWR)) u_eswp_device(.clock(clock), .srst(srst), .clkEn(1'b1), .link(link),
        .hwAddr(hwAddr), .is8k(is8k), .nvValid(1'b1), .nvImage(4'h6), .protReg(protReg),
        .arrayWrStb(arrayWrStb), .arrayWrAddr(), .arrayWrData(), .busy(busy));
    eswp_host u_eswp_host(.clock(clock), .srst(srst), .clkEn(1'b1), .link(link), .cmdValid(cmdValid),
        .cmdRead(cmdRead), .cmdHwAddr(cmdHwAddr), .cmdValue(cmdValue), .cmdLock(cmdLock),
        .cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData), .rspNack(rspNack));
    eswp_link_sva #(.TWR_CYCLES(TWR)) u_eswp_link_sva(.clock(clock), .srst(srst), .scl(link.scl),
        .sdaDevOe(link.sdaDevOe), .protReg(protReg), .nvImage(4'h6), .busy(busy),
        .cmdReady(cmdReady), .rspValid(rspValid), .rspNack(rspNack));
    always #50 clock = ~clock;
    // ==========================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask
    task automatic complete_run();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // one command, held until the host takes it, then wait for the answer
    task automatic doCmd(input logic rd, input logic [1:0] h, input logic [3:0] v, input logic l);
        do @(posedge clock); while (cmdReady !== 1'b1);
        cmdValid <= 1'b1;
        cmdRead <= rd;
        cmdHwAddr <= h;
        cmdValue <= v;
        cmdLock <= l;
        @(posedge clock);
        cmdValid <= 1'b0;
        do @(negedge clock); while (rspValid !== 1'b1);
        repeat (10) @(negedge clock);
    endtask
    // ==========================================
    // main sequence
    initial begin
        repeat (5) @(posedge clock);
        srst <= 1'b0;
        repeat (4) @(negedge clock);
        expReg = 4'h6;
        bz = 1'b0;
        chk("restore", {4'h0, expReg}, {4'h0, protReg});
        for (int i = 0; i < 14; i++) begin
            seed = lfsr(seed);
            @(posedge clock);
            is8k <= seed[4];
            hw = (i % 3 == 2) ? seed[6:5] : hwAddr;
            lk = (i == 9);
            // bit 2 of the address is a don't-care only on the larger variant
            ok = (hw[1] == hwAddr[1]) && (seed[4] || hw[0] == hwAddr[0]) && !bz;
            doCmd(1'b0, hw, seed[3:0], lk);
            chk("write nack", {7'h0, !ok}, {7'h0, rspNack});
            acc = ok && !expReg[0];
            if (acc) begin
                expReg = {seed[3:1], lk};
            end
            // a refused write while busy leaves the earlier write cycle still running
            chk("busy", {7'h0, acc || bz}, {7'h0, busy});
            chk("reg", {4'h0, expReg}, {4'h0, protReg});
            bz = acc && seed[7] && i != 13 && i != 8;
            if (!bz) begin
                do @(negedge clock); while (busy !== 1'b0);
                doCmd(1'b1, hwAddr, 4'h0, 1'b0);
                chk("read", {4'h0, expReg}, rspData);
                chk("read nack", 8'h00, {7'h0, rspNack});
            end
        end
        complete_run();
    end
    initial begin
        repeat (60000) @(posedge clock);
        n_mismatch++;
        complete_run();
    end
endmodule
`default_nettype wire
